/* File: hw/vms_pkg.sv */
// constants and types for the velocity mode status word block
// assumes one 100 MHz control clock and a synchronous active-low reset
package vms_pkg;

    // ****************************************************************
    // status word layout
    // ****************************************************************
    localparam int unsigned VMS_SW_W          = 16;
    localparam int unsigned VMS_BIT_TORQUE    = 15;
    localparam int unsigned VMS_BIT_RSV14     = 14;
    localparam int unsigned VMS_BIT_RSV13     = 13;
    localparam int unsigned VMS_BIT_SPEED0    = 12;
    localparam int unsigned VMS_BIT_LIMIT     = 11;
    localparam int unsigned VMS_BIT_TARGET    = 10;
    localparam int unsigned VMS_BIT_REMOTE    = 9;
    localparam int unsigned VMS_BIT_RSV8      = 8;
    localparam int unsigned VMS_BIT_WARNING   = 7;
    localparam int unsigned VMS_DSM_W         = 7;

    // ****************************************************************
    // widths and reset values
    // ****************************************************************
    localparam int unsigned VMS_SPEED_W       = 32;
    localparam int unsigned VMS_HALT_OPT_W    = 16;
    localparam int unsigned VMS_WARN_W        = 8;
    localparam logic [15:0] VMS_SW_RESET      = 16'h0000;
    localparam logic [15:0] VMS_HALT_OPT_RST  = 16'h0000;
    localparam logic [31:0] VMS_SPEED_RST     = 32'h0000_0000;

    // continuous operation sub-mode, controlword bits 13:12
    typedef enum logic [1:0] {
        VMS_MODE_POSITION = 2'b00,
        VMS_MODE_SPEED    = 2'b01,
        VMS_MODE_PUSH     = 2'b10,
        VMS_MODE_TORQUE   = 2'b11
    } vms_mode_e;

    // judgement of the speed-reached window
    typedef enum logic {
        VMS_REACH_BAND  = 1'b0,
        VMS_REACH_ABOVE = 1'b1
    } vms_reach_e;

    typedef struct packed {
        logic [15:0] status;
        logic        attained;
        logic        run_allowed;
        logic [15:0] stop_method;
        vms_mode_e   sub_mode;
        logic        ramp_bypass;
        logic [31:0] start_speed;
        logic        live;
    } vms_state_s;

endpackage

/* File: hw/vms_speed_window.sv */
// speed-reached comparator between command speed and target velocity
// assumes signed speeds in Hz and an unsigned tolerance in Hz
`timescale 1ns/10ps
module vms_speed_window
    import vms_pkg::*;
(
    input  wire logic signed [31:0] speed_cmd,
    input  wire logic signed [31:0] target_velocity,
    input  wire logic        [31:0] reach_range,
    input  wire vms_reach_e         reach_mode_sel,
    output logic                    reached
);

    logic signed [32:0] diff;
    logic        [32:0] diff_abs;
    logic        [32:0] cmd_abs;
    logic        [32:0] tgt_abs;

    always_comb begin
        diff     = 33'(speed_cmd) - 33'(target_velocity);
        diff_abs = diff[32] ? 33'(-diff) : 33'(diff);
        cmd_abs  = speed_cmd[31] ? 33'(-33'(speed_cmd)) : 33'(speed_cmd);
        tgt_abs  = target_velocity[31] ? 33'(-33'(target_velocity)) : 33'(target_velocity);
        // above mode: magnitude inside tolerance below target or beyond it
        if (reach_mode_sel == VMS_REACH_ABOVE) begin
            reached = (cmd_abs + {1'b0, reach_range}) >= tgt_abs;
        end else begin
            reached = diff_abs <= {1'b0, reach_range};
        end
    end

endmodule

/* File: hw/vms_status_word.sv */
// velocity mode status word generator and sub-mode control outputs
// assumes all inputs synchronous to ref_clk; profile generator is outside
//
// Functional notes
// - bit 15 set while load sits at motor torque ceiling, else clear
// - bit 12 is one exactly when internal speed command is zero
// - bit 11 is one when any end sensor, inhibit, soft or mech limit active
// - halt clear: bit 10 mirrors the speed attained output
// - halt set: bit 10 is one only once speed command reaches zero
// - speed tolerance comes from reach mode select and range setting
// - bit 9 becomes one once initialization has completed
// - bit 7 follows warning causes, clears itself when all vanish
// - torque sub-mode starts directly at target velocity without ramp
// - controlword halt bit: zero allows run, one stops by halt option
// - controlword bits 13:12 select sub-mode, taking effect at the next ref_clk edge
`timescale 1ns/10ps
module vms_status_word
    import vms_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    input  wire logic                      halt_req,
    input  wire logic [1:0]                op_type,
    input  wire logic [15:0]               halt_option_code,
    input  wire logic signed [31:0]        speed_cmd,
    input  wire logic signed [31:0]        target_velocity,
    input  wire logic signed [31:0]        starting_speed,
    input  wire vms_reach_e                reach_mode_sel,
    input  wire logic [31:0]               reach_range,
    input  wire logic                      torque_ceiling_hit,
    input  wire logic                      forward_end_sensor,
    input  wire logic                      reverse_end_sensor,
    input  wire logic                      forward_motion_inhibit,
    input  wire logic                      reverse_motion_inhibit,
    input  wire logic                      soft_limit_hit,
    input  wire logic                      mech_limit_hit,
    input  wire logic [7:0]                warning_causes,
    input  wire logic                      init_done,
    input  wire logic [6:0]                drive_state_bits,
    output logic [15:0]                    status_word,
    output logic                           speed_attained_output,
    output logic                           run_allowed,
    output logic [15:0]                    stop_method,
    output vms_mode_e                      sub_mode,
    output logic                           ramp_bypass,
    output logic signed [31:0]             start_speed
);

    // ****************************************************************
    // state
    // ****************************************************************
    vms_state_s state_q;
    vms_state_s state_d;
    logic       window_hit;
    logic       speed_zero;
    logic       limit_any;

    vms_speed_window u_window (
        .speed_cmd       (speed_cmd),
        .target_velocity (target_velocity),
        .reach_range     (reach_range),
        .reach_mode_sel  (reach_mode_sel),
        .reached         (window_hit)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        speed_zero = (speed_cmd == VMS_SPEED_RST);
        limit_any  = forward_end_sensor | reverse_end_sensor
                   | forward_motion_inhibit | reverse_motion_inhibit
                   | soft_limit_hit | mech_limit_hit;
        state_d = state_q;
        state_d.live = 1'b1;
        state_d.status[VMS_DSM_W-1:0]       = drive_state_bits;
        state_d.status[VMS_BIT_TORQUE]      = torque_ceiling_hit;
        state_d.status[VMS_BIT_RSV14]       = 1'b0;
        state_d.status[VMS_BIT_RSV13]       = 1'b0;
        state_d.status[VMS_BIT_RSV8]        = 1'b0;
        state_d.status[VMS_BIT_SPEED0]      = speed_zero;
        state_d.status[VMS_BIT_LIMIT]       = limit_any;
        state_d.status[VMS_BIT_WARNING]     = |warning_causes;
        // remote stays up once set; only a reset takes it down
        state_d.status[VMS_BIT_REMOTE]      = state_q.status[VMS_BIT_REMOTE]
                                            | init_done;
        state_d.attained = window_hit;
        // the halted case judges the live command, not the window
        if (halt_req) begin
            state_d.status[VMS_BIT_TARGET]  = speed_zero;
        end else begin
            state_d.status[VMS_BIT_TARGET]  = window_hit;
        end
        state_d.run_allowed = ~halt_req;
        state_d.stop_method = halt_option_code;
        state_d.sub_mode    = vms_mode_e'(op_type);
        // torque control is rectangular: no ramp, first step at target
        if (vms_mode_e'(op_type) == VMS_MODE_TORQUE) begin
            state_d.ramp_bypass = 1'b1;
            state_d.start_speed = target_velocity;
        end else begin
            state_d.ramp_bypass = 1'b0;
            state_d.start_speed = starting_speed;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_q.status      <= VMS_SW_RESET;
            state_q.attained    <= 1'b0;
            state_q.run_allowed <= 1'b0;
            state_q.stop_method <= VMS_HALT_OPT_RST;
            state_q.sub_mode    <= VMS_MODE_POSITION;
            state_q.ramp_bypass <= 1'b0;
            state_q.start_speed <= VMS_SPEED_RST;
            state_q.live        <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign status_word           = state_q.status;
    assign speed_attained_output = state_q.attained;
    assign run_allowed           = state_q.run_allowed;
    assign stop_method           = state_q.stop_method;
    assign sub_mode              = state_q.sub_mode;
    assign ramp_bypass           = state_q.ramp_bypass;
    assign start_speed           = state_q.start_speed;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // live gates out the first edge after release, where flops hold reset values
    // reset_n in an antecedent skips the release edge, whose next output is still reset
    chk_torque_flag: assert property (state_q.live |->
        status_word[VMS_BIT_TORQUE] == $past(torque_ceiling_hit))
        else $error("torque ceiling flag wrong");

    chk_speed_zero: assert property (state_q.live |->
        status_word[VMS_BIT_SPEED0] == ($past(speed_cmd) == 32'h0000_0000))
        else $error("zero speed flag wrong");

    chk_limit_or: assert property (
        reset_n && (mech_limit_hit || forward_motion_inhibit)
        |=> status_word[VMS_BIT_LIMIT])
        else $error("limit flag missed a source");

    chk_target_run: assert property (state_q.live && $past(!halt_req) |->
        status_word[VMS_BIT_TARGET] == speed_attained_output)
        else $error("target flag not mirroring attained output");

    chk_target_halt: assert property (reset_n &&
        halt_req && speed_cmd != 0 |=>
        !status_word[VMS_BIT_TARGET])
        else $error("target flag set during halt deceleration");

    chk_window_band: assert property (
        reset_n && reach_mode_sel == VMS_REACH_BAND && speed_cmd == target_velocity
        |=> speed_attained_output)
        else $error("speed window missed exact match");

    chk_remote_hold: assert property (reset_n && init_done |=>
        status_word[VMS_BIT_REMOTE] [*8])
        else $error("remote flag dropped after init");

    chk_warn_clear: assert property (reset_n && $fell(|warning_causes) |=>
        !status_word[VMS_BIT_WARNING])
        else $error("warning flag did not self clear");

    chk_torque_start: assert property (reset_n && op_type == 2'b11 |=>
        ramp_bypass && start_speed == $past(target_velocity))
        else $error("torque mode did not start at target");

    chk_halt_run: assert property (state_q.live |->
        run_allowed != $past(halt_req))
        else $error("run allowed not following halt");

    chk_mode_sel: assert property (state_q.live |->
        sub_mode == $past(op_type))
        else $error("sub mode not applied next cycle");

    chk_reserved_zero: assert property (
        status_word[VMS_BIT_RSV14] == 1'b0 && status_word[VMS_BIT_RSV13] == 1'b0
        && status_word[VMS_BIT_RSV8] == 1'b0)
        else $error("reserved status bits not zero");

    chk_limit_all: assert property (state_q.live |->
        status_word[VMS_BIT_LIMIT] == $past(limit_any))
        else $error("limit flag not the or of its sources");

    chk_warn_follow: assert property (state_q.live |->
        status_word[VMS_BIT_WARNING] == (|$past(warning_causes)))
        else $error("warning flag not following causes");

    chk_target_zero: assert property (state_q.live && $past(halt_req) |->
        status_word[VMS_BIT_TARGET] == status_word[VMS_BIT_SPEED0])
        else $error("halted target flag not tracking zero speed");

    chk_window_above: assert property (reset_n &&
        reach_mode_sel == VMS_REACH_ABOVE && speed_cmd == target_velocity
        |=> speed_attained_output)
        else $error("above window missed exact match");

    chk_window_miss: assert property (reset_n &&
        reach_mode_sel == VMS_REACH_BAND && reach_range == 32'h0000_0000
        && speed_cmd != target_velocity |=> !speed_attained_output)
        else $error("band window hit with zero range and unequal speeds");

    chk_stop_copy: assert property (state_q.live |->
        stop_method == $past(halt_option_code))
        else $error("stop method not copied from halt option");

    chk_start_plain: assert property (reset_n && op_type != 2'b11 |=>
        !ramp_bypass && start_speed == $past(starting_speed))
        else $error("ramp bypass outside torque mode");

    cov_torque_mode: cover property (op_type == 2'b11 ##1 ramp_bypass);
    cov_halt_stop: cover property (halt_req && speed_cmd != 0 ##[1:50]
        status_word[VMS_BIT_TARGET]);
    cov_limit: cover property (status_word[VMS_BIT_LIMIT]);
    cov_warn_cycle: cover property (status_word[VMS_BIT_WARNING] ##[1:20]
        !status_word[VMS_BIT_WARNING]);

endmodule

/* File: dv/vms_master_model.sv */
// far-side controller model: splits the controlword into halt and type fields
// assumes the bench writes the controlword just after a rising edge of ref_clk
`timescale 1ns/10ps
module vms_master_model
    import vms_pkg::*;
(
    input  wire logic [15:0] controlword,
    output logic             halt_req,
    output logic [1:0]       op_type
);
    // bit 8 requests a halt, bits 13:12 pick the sub-mode at once
    assign halt_req = controlword[8];
    assign op_type  = controlword[13:12];
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the velocity mode status word block
// assumes one ref_clk domain and one cycle from input to registered output
`timescale 1ns/10ps
module tb_top
    import vms_pkg::*;
;
    typedef struct packed {
        logic [15:0] sw;
        logic [52:0] ctl;
    } vms_note_s;
    logic               ref_clk, reset_n, halt_req, init_done, att, run, byp;
    logic               tq, fls, rls, fmi, rmi, sl, ml;
    logic        [15:0] cw, hoc, sw, stop;
    logic        [1:0]  op_type;
    logic signed [31:0] spd, tgt, sts, st;
    logic        [31:0] rr;
    logic        [7:0]  wc;
    logic        [6:0]  dsb;
    vms_reach_e         rms;
    vms_mode_e          mode;
    int                 n_fail, cmp_count;
    bit                 seen;
    vms_note_s          notes[$];
    vms_note_s          nt;

    vms_master_model i_master (.controlword(cw), .halt_req(halt_req), .op_type(op_type));
    vms_status_word i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .halt_req(halt_req),
        .op_type(op_type), .halt_option_code(hoc), .speed_cmd(spd), .target_velocity(tgt),
        .starting_speed(sts), .reach_mode_sel(rms), .reach_range(rr),
        .torque_ceiling_hit(tq), .forward_end_sensor(fls), .reverse_end_sensor(rls),
        .forward_motion_inhibit(fmi), .reverse_motion_inhibit(rmi), .soft_limit_hit(sl),
        .mech_limit_hit(ml), .warning_causes(wc), .init_done(init_done),
        .drive_state_bits(dsb), .status_word(sw), .speed_attained_output(att),
        .run_allowed(run), .stop_method(stop), .sub_mode(mode), .ramp_bypass(byp),
        .start_speed(st));

    // ****************************************************************
    // reference model
    // ****************************************************************
    function automatic vms_note_s model();
        vms_note_s n;
        longint    c, t;
        logic      a;
        c = spd;
        t = tgt;
        a = (rms == VMS_REACH_BAND) ? ((c > t ? c - t : t - c) <= rr)
                                    : ((c < 0 ? -c : c) + rr >= (t < 0 ? -t : t));
        n.sw = 16'h0000;
        n.sw[15] = tq;
        n.sw[12] = (spd == 0);
        n.sw[11] = |{fls, rls, fmi, rmi, sl, ml};
        n.sw[10] = halt_req ? (spd == 0) : a;
        n.sw[9] = seen;
        n.sw[7] = |wc;
        n.sw[6:0] = dsb;
        n.ctl = {a, ~halt_req, hoc, op_type, op_type == 2'b11, op_type == 2'b11 ? tgt : sts};
        return n;
    endfunction

    // ****************************************************************
    // drivers and checkers
    // ****************************************************************
    task automatic apply();
        @(posedge ref_clk);
        #1;
        if (!reset_n) seen = 0;
        else if (init_done === 1'b1) seen = 1;
        notes.push_back(reset_n ? model() : '0);
    endtask
    task automatic do_reset();
        @(posedge ref_clk);
        reset_n <= 1'b0;
        // a stale init pulse would latch remote right after release
        init_done <= 1'b0;
        repeat (11) @(posedge ref_clk);
        #1;
        seen = 0;
        notes.push_back('0);
        @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rnd_in();
        int t;
        int s;
        t = int'($urandom_range(200)) - 100;
        case ($urandom_range(3))
            0: s = 0;
            1: s = t;
            default: s = t + int'($urandom_range(20)) - 10;
        endcase
        tgt <= t;
        spd <= s;
        cw <= 16'($urandom);
        hoc <= 16'($urandom);
        sts <= $urandom_range(5000);
        rms <= vms_reach_e'($urandom_range(1));
        rr <= $urandom_range(8);
        {wc, tq, fls, rls, fmi, rmi, sl, ml} <= 15'($urandom & $urandom & $urandom);
        init_done <= ($urandom_range(30) == 0);
        dsb <= 7'($urandom);
    endtask
    task automatic cmp_sw(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected status at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_ctl(input logic [52:0] g, input logic [52:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected control at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // outputs settle well before the falling edge
    always @(negedge ref_clk) begin
        if (notes.size() > 0) begin
            nt = notes.pop_front();
            cmp_sw(sw, nt.sw);
            cmp_ctl({att, run, stop, mode, byp, st}, nt.ctl);
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {reset_n, init_done, tq, fls, rls, fmi, rmi, sl, ml} = '0;
        {cw, hoc, spd, tgt, sts, rr, wc, dsb} = '0;
        rms = VMS_REACH_BAND;
        void'($urandom(94));
        do_reset();
        apply();
        @(posedge ref_clk) init_done <= 1'b1;
        apply();
        @(posedge ref_clk) init_done <= 1'b0;
        apply();
        $display("test remote done");
        @(posedge ref_clk) {cw, spd, tgt} <= {16'h0100, 32'sd50, 32'sd50};
        apply();
        @(posedge ref_clk) spd <= 0;
        apply();
        @(posedge ref_clk) cw <= 16'h0000;
        apply();
        $display("test halt done");
        for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk) cw <= 16'(m << 12);
            apply();
        end
        $display("test modes done");
        repeat (400) begin
            @(posedge ref_clk);
            rnd_in();
            apply();
        end
        $display("test random done");
        do_reset();
        @(posedge ref_clk) init_done <= 1'b0;
        apply();
        $display("test reset done");
        for (int i = 0; i < 10 && notes.size() > 0; i++) @(posedge ref_clk);
        if (notes.size() > 0) n_fail++;
        results();
    end
endmodule
